// *** asc_ctrl.v ***
// Purpose: Host controller driving an asynchronous 256K x 16 static memory.
// Assumes: One request at a time; req_ready high means a request with a lane low is taken.
// Notes: Pins change only on clock edges; phases are counted in cycles.
`include "asc_regs.vh"
module asc_ctrl (
  clk,
  resetn,
  req_valid,
  req_ready,
  req_write,
  req_addr,
  req_wdata,
  req_lane_n,
  rsp_valid,
  rsp_rdata,
  word_address,
  device_select_n,
  store_strobe_n,
  drive_enable_n,
  low_lane_enable_n,
  high_lane_enable_n,
  data_pins_in,
  data_pins_out,
  data_pins_oe_n
);
  input wire clk;
  input wire resetn;
  input wire req_valid;
  output wire req_ready;
  input wire req_write;
  input wire [17:0] req_addr;
  input wire [15:0] req_wdata;
  input wire [1:0] req_lane_n;
  output reg rsp_valid;
  output reg [15:0] rsp_rdata;
  output reg [17:0] word_address;
  output reg device_select_n;
  output reg store_strobe_n;
  output reg drive_enable_n;
  output reg low_lane_enable_n;
  output reg high_lane_enable_n;
  input wire [15:0] data_pins_in;
  output reg [15:0] data_pins_out;
  output reg data_pins_oe_n;

  // ==========================================================
  // States and counts
  localparam [5:0] ST_IDLE = 6'b00_0001;
  localparam [5:0] ST_RD = 6'b00_0010;
  localparam [5:0] ST_RD_END = 6'b00_0100;
  localparam [5:0] ST_WR_OFF = 6'b00_1000;
  localparam [5:0] ST_WR = 6'b01_0000;
  localparam [5:0] ST_REC = 6'b10_0000;
  // Read holds four cycles of synchroniser delay beyond access time
  localparam integer RD_INT = `ASC_RC_CYC + 4;
  localparam integer OFF_INT = `ASC_OHZ_CYC;
  localparam integer WP_INT = `ASC_WP_CYC;
  localparam integer REC_INT = `ASC_OHZ_CYC;
  // Counts cut to the counter width on purpose
  localparam [4:0] RD_CNT = RD_INT[4:0];
  localparam [4:0] OFF_CNT = OFF_INT[4:0];
  localparam [4:0] WP_CNT = WP_INT[4:0];
  localparam [4:0] REC_CNT = REC_INT[4:0];

  reg [5:0] state;
  reg [4:0] cnt;
  wire [15:0] rd_sync;

  asc_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .din(data_pins_in),
    .dout(rd_sync)
  );

  // Lane enables both high would give standby: no access
  function lanes_ok;
    input [1:0] l;
    begin
      lanes_ok = ~(l[0] & l[1]);
    end
  endfunction

  assign req_ready = (state == ST_IDLE);

  // ==========================================================
  // Sequencer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt <= 5'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      word_address <= 18'h0_0000;
      device_select_n <= 1'b1;
      store_strobe_n <= 1'b1;
      drive_enable_n <= 1'b1;
      low_lane_enable_n <= 1'b1;
      high_lane_enable_n <= 1'b1;
      data_pins_out <= 16'h0000;
      data_pins_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid && lanes_ok(req_lane_n)) begin
            // Address set while select and strobe still high
            word_address <= req_addr;
            low_lane_enable_n <= req_lane_n[0];
            high_lane_enable_n <= req_lane_n[1];
            device_select_n <= 1'b0;
            cnt <= 5'h0;
            if (req_write) begin
              drive_enable_n <= 1'b1;
              data_pins_out <= req_wdata;
              state <= ST_WR_OFF;
            end else begin
              drive_enable_n <= 1'b0;
              state <= ST_RD;
            end
          end
        end
        ST_RD: begin
          // Data follows address asynchronously; sample after access
          cnt <= cnt + 5'h1;
          if (cnt == RD_CNT) begin
            rsp_rdata <= rd_sync;
            rsp_valid <= 1'b1;
            device_select_n <= 1'b1;
            drive_enable_n <= 1'b1;
            cnt <= 5'h0;
            state <= ST_RD_END;
          end
        end
        ST_RD_END: begin
          // Let memory outputs turn off before anything else
          cnt <= cnt + 5'h1;
          if (cnt == OFF_CNT) begin
            low_lane_enable_n <= 1'b1;
            high_lane_enable_n <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_WR_OFF: begin
          // Strobe low disables memory drivers; data driven on the same edge
          store_strobe_n <= 1'b0;
          data_pins_oe_n <= 1'b0;
          cnt <= 5'h0;
          state <= ST_WR;
        end
        ST_WR: begin
          cnt <= cnt + 5'h1;
          if (cnt == WP_CNT) begin
            // Strobe rises first and ends the write
            store_strobe_n <= 1'b1;
            cnt <= 5'h0;
            state <= ST_REC;
          end
        end
        ST_REC: begin
          // Data held one cycle past strobe edge, then released
          data_pins_oe_n <= 1'b1;
          device_select_n <= 1'b1;
          cnt <= cnt + 5'h1;
          if (cnt == REC_CNT) begin
            low_lane_enable_n <= 1'b1;
            high_lane_enable_n <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // asc_ctrl

// *** asc_ctrl_checker.sv ***
// Purpose: Pin checks for the controller.
// Assumes: Bound to asc_ctrl.
// Notes: Counts follow the hand-over timing.
module asc_ctrl_checker (
  input wire clk, resetn, rsp_valid,
  input wire [17:0] word_address,
  input wire device_select_n, store_strobe_n, drive_enable_n,
  input wire low_lane_enable_n, high_lane_enable_n,
  input wire [15:0] data_pins_out,
  input wire data_pins_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rd8;
    (!device_select_n && !drive_enable_n) [*8];
  endsequence
  sequence s_wr7;
    (!store_strobe_n && !device_select_n && !data_pins_oe_n) [*7];
  endsequence
  a_rd_len:
    assert property ($fell(drive_enable_n) |-> s_rd8 ##1 s_rd8 ##[1:2] rsp_valid) else $error("rd");
  a_wr_pulse:
    assert property ($fell(store_strobe_n) |-> s_wr7 ##[1:4] $rose(store_strobe_n)) else $error("wr");
  a_wr_end:
    assert property ($rose(store_strobe_n) |-> !device_select_n ##1 $rose(device_select_n))
    else $error("end");
  a_addr_hold:
    assert property ($changed(word_address) |-> $past(device_select_n)) else $error("addr");
  a_no_fight:
    assert property (!data_pins_oe_n |-> !store_strobe_n || drive_enable_n) else $error("bus");
  a_rd_quiet:
    assert property (!drive_enable_n |-> store_strobe_n) else $error("quiet");
  a_stb_sel:
    assert property (!store_strobe_n |-> !device_select_n) else $error("sel");
  a_lane_on:
    assert property (!device_select_n |-> !(low_lane_enable_n && high_lane_enable_n))
    else $error("lane");
endmodule // asc_ctrl_checker
bind asc_ctrl asc_ctrl_checker u_chk (.*);

// *** asc_mem.sv ***
// Purpose: Behavioural static memory on the controller pins.
// Assumes: Levels and edges only, no timing.
// Notes: Undriven lanes show the inverted word.
module asc_mem (
  input wire logic [17:0] word_address,
  input wire logic device_select_n, store_strobe_n, drive_enable_n, data_pins_oe_n,
  input wire logic low_lane_enable_n, high_lane_enable_n,
  input wire logic [15:0] data_pins_out,
  output logic [15:0] data_pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] m [int];
  logic [15:0] q, k;
  wire [1:0] ln = {high_lane_enable_n, low_lane_enable_n};
  wire wr = !device_select_n && !store_strobe_n && ln != 2'b11;
  wire rd = !device_select_n && store_strobe_n && !drive_enable_n;
  always @(negedge wr) begin
    q = m.exists(word_address) ? m[word_address] : 16'h0000;
    q = {ln[1] ? q[15:8] : data_pins_out[15:8], ln[0] ? q[7:0] : data_pins_out[7:0]};
    m[word_address] = q;
  end
  always @(word_address, rd, ln, data_pins_oe_n, data_pins_out) begin
    k = m.exists(word_address) ? m[word_address] : 16'h0000;
    data_pins_in = data_pins_oe_n ? ~k : data_pins_out;
    if (rd && !ln[0]) data_pins_in[7:0] = k[7:0];
    if (rd && !ln[1]) data_pins_in[15:8] = k[15:8];
  end
endmodule // asc_mem

// *** asc_regs.vh ***
// Purpose: Constants for the asynchronous static memory port controller.
// Assumes: 200 MHz clock, 5 ns period; 55 ns speed grade of the memory.
// Notes: Timing counts derive from printed times by rounding.
//
// How it works
// - Write needs strobe, select, a lane low
// - Write ends when select or strobe rises
// - Select or strobe high during address change
// - Drive data only after memory outputs disabled
// - Address valid by select falling edge
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
`define ASC_ADDR_W 18
`define ASC_DATA_W 16
`define ASC_CLK_PS 5000
// Least times in ps: cycle, write pulse, data setup, output-off
`define ASC_T_RC_PS 55000
`define ASC_T_WP_PS 40000
`define ASC_T_DW_PS 25000
`define ASC_T_OHZ_PS 20000
`define ASC_RC_CYC ((`ASC_T_RC_PS + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_WP_CYC ((`ASC_T_WP_PS + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_DW_CYC ((`ASC_T_DW_PS + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_OHZ_CYC ((`ASC_T_OHZ_PS + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_CNT_W 5
`endif

// *** asc_sync.v ***
// Purpose: Three-stage synchroniser for the read data pins.
// Assumes: Input comes from the memory, outside the clock domain.
// Notes: Output updates only when stages two and three agree.
module asc_sync (
  clk,
  resetn,
  din,
  dout
);
  input wire clk;
  input wire resetn;
  input wire [15:0] din;
  output reg [15:0] dout;
  reg [15:0] s1;
  reg [15:0] s2;
  reg [15:0] s3;
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            dout[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // asc_sync

// *** test_async_sram_word_byte_port.sv ***
// Purpose: Self-checking bench for the controller.
// Assumes: Memory model on the pins.
// Notes: One request at a time.
module test_async_sram_word_byte_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, req_valid, req_ready, req_write, rsp_valid, data_pins_oe_n;
  logic device_select_n, store_strobe_n, drive_enable_n, low_lane_enable_n, high_lane_enable_n;
  logic [17:0] req_addr, word_address;
  logic [15:0] req_wdata, rsp_rdata, data_pins_in, data_pins_out;
  logic [1:0] req_lane_n;
  int num_errors = 0, n_tests = 0, cyc = 0, n;
  asc_ctrl uut (.*);
  asc_mem mem (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] l);
    @(posedge clk);
    {req_valid, req_write, req_addr, req_wdata, req_lane_n} <= {1'b1, w, a, d, l};
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [1:0] l, input logic [15:0] e);
    op(1'b0, a, 16'h0000, l);
    for (int i = 0; i < 40 && rsp_valid !== 1'b1; i++) @(negedge clk);
    chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
    chk("rsp_rdata", rsp_rdata & {{8{~l[1]}}, {8{~l[0]}}}, e);
  endtask
  task automatic t_word;
    op(1'b1, 18'h3_ffff, 16'h1234, 2'b00);
    op(1'b1, 18'h1_ffff, 16'h5678, 2'b00);
    rd(18'h3_ffff, 2'b00, 16'h1234);
    rd(18'h1_ffff, 2'b00, 16'h5678);
    $display("t_word done");
  endtask
  task automatic t_lane;
    op(1'b1, 18'h0_0005, 16'habcd, 2'b00);
    op(1'b1, 18'h0_0005, 16'h0011, 2'b10);
    rd(18'h0_0005, 2'b01, 16'hab00);
    rd(18'h0_0005, 2'b10, 16'h0011);
    n = 0;
    op(1'b1, 18'h0_0005, 16'hffff, 2'b11);
    repeat (20) @(negedge clk) if (device_select_n !== 1'b1) n++;
    chk("select", n[15:0], 16'h0000);
    rd(18'h0_0005, 2'b00, 16'hab11);
    $display("t_lane done");
  endtask
  task tally_and_finish;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    {req_valid, req_write, req_addr, req_wdata, req_lane_n} = 38'h00_0000_0000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_word;
    t_lane;
    tally_and_finish;
  end
endmodule // test_async_sram_word_byte_port
